// file: rtl/cell_pkg.sv
// constants for the byte eeprom access controller
// assumes a single core clock and an active-low power-up reset
// What this block does
// - 128 byte cells, index 00h to 7Fh
// - each byte write erases the cell first
// - write length set by internal timer
// - core access survives data protect fuse
// - index bit 7 ignored, reads zero
// - control bits 7 to 4 read zero
// - fetch and program go: set only, hardware clears
// - write needs permit; program_go starts it
// - permit clear at power-up
// - reset during write sets abort flag, except a reset in the write's first cycle
// - aborting reset clears byte and index
// - write done sets done flag, software clears
// - unlock port stores nothing, reads zero
// - byte register eight bits, reset zero
// - 55h then AAh then go, exact timing
// - go blocked while permit clear
// - clearing permit mid-write changes nothing
// - read byte next cycle, held afterwards
package cell_pkg;
  localparam logic [7:0] CELL_BYTE_ADDR = 8'h9A;
  localparam logic [7:0] CELL_INDEX_ADDR = 8'h9B;
  localparam logic [7:0] CELL_CTL_ADDR = 8'h9C;
  localparam logic [7:0] UNLOCK_ADDR = 8'h9D;
  localparam int FETCH_GO_BIT = 0;
  localparam int PROGRAM_GO_BIT = 1;
  localparam int PERMIT_BIT = 2;
  localparam int ABORT_BIT = 3;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int UNLOCK_WINDOW = 1;
  localparam int DEPTH = 128;
  localparam int WRITE_TIME_NS = 4000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT55 = 2'b01,
    KEY_ARMED = 2'b11
  } key_state_t;
endpackage

// file: rtl/cell_access.sv
// byte eeprom access controller with core register port and cell array
// assumes synchronous core register strobes, one access a cycle
`timescale 1ns/1ns
`default_nettype none
module cell_access #(
  parameter int WRITE_CYCLES = cell_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_event,
  input wire logic data_protect_fuse,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic done_flag_clear,
  output logic program_done_flag,
  output logic write_busy,
  input wire logic prog_rd,
  input wire logic [6:0] prog_index,
  output logic [7:0] prog_rdata
);
  logic [7:0] cell_array [cell_pkg::DEPTH];
  logic [7:0] cell_byte_reg;
  logic [6:0] cell_index_reg;
  logic fetch_go;
  logic program_go;
  logic program_permit;
  logic program_abort_flag;
  logic write_seen;
  logic [15:0] write_count;
  logic [6:0] write_index;
  logic [7:0] write_byte;
  logic first_done;
  cell_pkg::key_state_t key_state;
  cell_pkg::key_state_t next_key_state;
  logic [7:0] ctl_view;

  wire hit_byte = reg_wr && (reg_addr == cell_pkg::CELL_BYTE_ADDR);
  wire hit_index = reg_wr && (reg_addr == cell_pkg::CELL_INDEX_ADDR);
  wire hit_ctl = reg_wr && (reg_addr == cell_pkg::CELL_CTL_ADDR);
  wire hit_key = reg_wr && (reg_addr == cell_pkg::UNLOCK_ADDR);
  wire set_fetch = hit_ctl && reg_wdata[cell_pkg::FETCH_GO_BIT] && !program_go;
  wire next_permit = hit_ctl ? reg_wdata[cell_pkg::PERMIT_BIT] : program_permit;
  wire start_write = hit_ctl && reg_wdata[cell_pkg::PROGRAM_GO_BIT] && !program_go
    && program_permit && (key_state == cell_pkg::KEY_ARMED);
  wire write_end = program_go && (write_count == 16'(WRITE_CYCLES - 1));
  wire prog_allowed = data_protect_fuse;

  always_comb begin
    next_key_state = cell_pkg::KEY_IDLE;
    if (hit_key && reg_wdata == cell_pkg::KEY_FIRST) begin
      next_key_state = cell_pkg::KEY_GOT55;
    end else if (hit_key && reg_wdata == cell_pkg::KEY_SECOND
        && key_state == cell_pkg::KEY_GOT55) begin
      next_key_state = cell_pkg::KEY_ARMED;
    end
  end

  assign ctl_view = {4'h0, program_abort_flag, program_permit, program_go, fetch_go};
  assign write_busy = program_go;

  always_comb begin
    unique case (reg_addr)
      cell_pkg::CELL_BYTE_ADDR: reg_rdata = cell_byte_reg;
      cell_pkg::CELL_INDEX_ADDR: reg_rdata = {1'b0, cell_index_reg};
      cell_pkg::CELL_CTL_ADDR: reg_rdata = ctl_view;
      default: reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_state <= cell_pkg::KEY_IDLE;
    end else begin
      key_state <= next_key_state;
    end
  end

  // interrupted-write tracker survives pin/watchdog reset, cleared at power-up and whenever no write is running
  always_ff @(posedge clk) begin
    if (por_event) begin
      write_seen <= 1'b0;
    end else if (!rstn) begin
      write_seen <= write_seen;
    end else begin
      write_seen <= program_go && !write_end;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_done <= 1'b0;
      program_abort_flag <= 1'b0;
    end else begin
      first_done <= 1'b1;
      if (!first_done && write_seen) begin
        program_abort_flag <= 1'b1;
      end else if (hit_ctl) begin
        program_abort_flag <= reg_wdata[cell_pkg::ABORT_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cell_byte_reg <= cell_pkg::RESET_BYTE;
      cell_index_reg <= 7'h00;
      fetch_go <= 1'b0;
      program_go <= 1'b0;
      program_permit <= 1'b0;
      write_count <= 16'h0000;
      write_index <= 7'h00;
      write_byte <= 8'h00;
    end else begin
      program_permit <= next_permit;
      if (set_fetch) begin
        cell_byte_reg <= cell_array[cell_index_reg];
      end else if (hit_byte) begin
        cell_byte_reg <= reg_wdata;
      end
      fetch_go <= set_fetch;
      if (hit_index) begin
        cell_index_reg <= reg_wdata[6:0];
      end
      if (start_write) begin
        program_go <= 1'b1;
        write_count <= 16'h0000;
        write_index <= cell_index_reg;
        write_byte <= cell_byte_reg;
      end else if (write_end) begin
        program_go <= 1'b0;
      end else if (program_go) begin
        write_count <= write_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      program_done_flag <= 1'b0;
    end else if (write_end) begin
      program_done_flag <= 1'b1;
    end else if (done_flag_clear) begin
      program_done_flag <= 1'b0;
    end
  end

  // erase then store happen as one replace at the end of the timed cycle
  always_ff @(posedge clk) begin
    if (write_end && rstn) begin
      cell_array[write_index] <= write_byte;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_rdata <= 8'h00;
    end else begin
      prog_rdata <= (prog_rd && prog_allowed) ? cell_array[prog_index] : 8'h00;
    end
  end

  // span of a timed write as seen by the checks
  localparam int WRITE_SPAN = WRITE_CYCLES;

  sequence s_key_first;
    hit_key && reg_wdata == cell_pkg::KEY_FIRST;
  endsequence

  sequence s_key_second;
    hit_key && reg_wdata == cell_pkg::KEY_SECOND;
  endsequence

  sequence s_go_request;
    hit_ctl && reg_wdata[cell_pkg::PROGRAM_GO_BIT] && program_permit && !program_go;
  endsequence

  property p_fetch_one_cycle;
    @(posedge clk) disable iff (!rstn)
    set_fetch |=> fetch_go && cell_byte_reg == $past(cell_array[cell_index_reg]);
  endproperty
  a_fetch_one_cycle: assert property (p_fetch_one_cycle)
    else $error("fetch did not return byte next cycle");

  property p_fetch_clears;
    @(posedge clk) disable iff (!rstn)
    fetch_go && !set_fetch |=> !fetch_go;
  endproperty
  a_fetch_clears: assert property (p_fetch_clears)
    else $error("fetch go not cleared by hardware");

  property p_go_needs_permit;
    @(posedge clk) disable iff (!rstn)
    $rose(program_go) |-> $past(program_permit) && $past(key_state) == cell_pkg::KEY_ARMED;
  endproperty
  a_go_needs_permit: assert property (p_go_needs_permit)
    else $error("write started without permit and key");

  property p_done_sets_flag;
    @(posedge clk) disable iff (!rstn)
    write_end |=> program_done_flag && !program_go;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("write end did not set done flag");

  property p_index_top_zero;
    @(posedge clk) disable iff (!rstn)
    reg_addr == cell_pkg::CELL_INDEX_ADDR |-> reg_rdata[7] == 1'b0;
  endproperty
  a_index_top_zero: assert property (p_index_top_zero)
    else $error("index bit 7 read non-zero");

  property p_ctl_upper_zero;
    @(posedge clk) disable iff (!rstn)
    reg_addr == cell_pkg::CELL_CTL_ADDR |-> reg_rdata[7:4] == 4'h0;
  endproperty
  a_ctl_upper_zero: assert property (p_ctl_upper_zero)
    else $error("control upper bits non-zero");

  property p_key_port_zero;
    @(posedge clk) disable iff (!rstn)
    reg_addr == cell_pkg::UNLOCK_ADDR |-> reg_rdata == 8'h00;
  endproperty
  a_key_port_zero: assert property (p_key_port_zero)
    else $error("unlock port read non-zero");

  property p_go_holds;
    @(posedge clk) disable iff (!rstn)
    program_go && !write_end |=> program_go;
  endproperty
  a_go_holds: assert property (p_go_holds)
    else $error("program go dropped early");

  property p_key_order;
    @(posedge clk) disable iff (!rstn)
    key_state == cell_pkg::KEY_ARMED |-> $past(key_state) == cell_pkg::KEY_GOT55;
  endproperty
  a_key_order: assert property (p_key_order)
    else $error("key armed without 55h first");

  property p_unlock_starts;
    @(posedge clk) disable iff (!rstn)
    s_key_first ##1 s_key_second ##1 s_go_request |=> program_go;
  endproperty
  a_unlock_starts: assert property (p_unlock_starts)
    else $error("full unlock sequence did not start write");

  property p_key_broken;
    @(posedge clk) disable iff (!rstn)
    hit_ctl && key_state != cell_pkg::KEY_ARMED |=> !$rose(program_go);
  endproperty
  a_key_broken: assert property (p_key_broken)
    else $error("write started without key sequence");

  property p_no_permit;
    @(posedge clk) disable iff (!rstn)
    hit_ctl && !program_permit |=> !$rose(program_go);
  endproperty
  a_no_permit: assert property (p_no_permit)
    else $error("write started with permit clear");

  property p_write_span;
    @(posedge clk) disable iff (!rstn)
    $rose(program_go) |-> ##WRITE_SPAN !program_go && program_done_flag;
  endproperty
  a_write_span: assert property (p_write_span)
    else $error("write length differs from timer count");

  property p_permit_kept;
    @(posedge clk) disable iff (!rstn)
    !hit_ctl |=> $stable(program_permit);
  endproperty
  a_permit_kept: assert property (p_permit_kept)
    else $error("permit changed without software write");

  property p_done_held;
    @(posedge clk) disable iff (!rstn)
    program_done_flag && !done_flag_clear |=> program_done_flag;
  endproperty
  a_done_held: assert property (p_done_held)
    else $error("done flag dropped without clear");

  property p_byte_holds;
    @(posedge clk) disable iff (!rstn)
    !set_fetch && !hit_byte |=> $stable(cell_byte_reg);
  endproperty
  a_byte_holds: assert property (p_byte_holds)
    else $error("byte register changed on its own");

  property p_index_holds;
    @(posedge clk) disable iff (!rstn)
    !hit_index |=> $stable(cell_index_reg);
  endproperty
  a_index_holds: assert property (p_index_holds)
    else $error("index register changed on its own");

  property p_prog_locked;
    @(posedge clk) disable iff (!rstn)
    prog_rd && !data_protect_fuse |=> prog_rdata == 8'h00;
  endproperty
  a_prog_locked: assert property (p_prog_locked)
    else $error("protected array read by programmer");

  property p_array_written;
    @(posedge clk) disable iff (!rstn)
    write_end |=> cell_array[$past(write_index)] == $past(write_byte);
  endproperty
  a_array_written: assert property (p_array_written)
    else $error("cell not replaced at write end");

  property p_abort_sets;
    @(posedge clk) disable iff (!rstn)
    !first_done && write_seen |=> program_abort_flag;
  endproperty
  a_abort_sets: assert property (p_abort_sets)
    else $error("interrupted write not flagged");

  property p_abort_clears;
    @(posedge clk) disable iff (!rstn)
    !first_done && write_seen |-> cell_byte_reg == cell_pkg::RESET_BYTE
      && cell_index_reg == 7'h00;
  endproperty
  a_abort_clears: assert property (p_abort_clears)
    else $error("byte or index kept after aborting reset");
endmodule
`default_nettype wire

// file: test/core_model.sv
// core software model driving the register port
// one access per edge, inputs set 1 ns after the edge
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic done_flag_clear
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    done_flag_clear = 1'b0;
  end
  // held until sampled, returns 1 ns after that edge
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = ~w;
    @(posedge clk);
    #1;
  endtask
  // key pair then control write, strictly back to back
  task automatic unlock_go(input logic [7:0] c);
    put(cell_pkg::UNLOCK_ADDR, cell_pkg::KEY_FIRST, 1'b1);
    put(cell_pkg::UNLOCK_ADDR, cell_pkg::KEY_SECOND, 1'b1);
    put(cell_pkg::CELL_CTL_ADDR, c, 1'b1);
    put(cell_pkg::CELL_CTL_ADDR, 8'h00, 1'b0);
  endtask
  task automatic clear_done();
    done_flag_clear = 1'b1;
    @(posedge clk);
    #1;
    done_flag_clear = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/tb_byte_eeprom_access_controller.sv
// self-checking bench for the eeprom access controller
// assumes the core model as register master, short write time
`timescale 1ns/1ns
`default_nettype none
module tb_byte_eeprom_access_controller;
  localparam int WC = 4;
  logic clk, rstn, por_event, fuse, prog_rd, program_done_flag, write_busy;
  logic [6:0] prog_index;
  logic [7:0] reg_rdata, prog_rdata, reg_addr, reg_wdata;
  logic reg_wr, reg_rd, done_flag_clear;
  int err_count, samples_checked;
  core_model core (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .done_flag_clear(done_flag_clear));
  cell_access #(.WRITE_CYCLES(WC)) uut (.clk(clk), .rstn(rstn), .por_event(por_event),
    .data_protect_fuse(fuse), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .done_flag_clear(done_flag_clear),
    .program_done_flag(program_done_flag), .write_busy(write_busy), .prog_rd(prog_rd),
    .prog_index(prog_index), .prog_rdata(prog_rdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    core.put(a, 8'h00, 1'b0);
    chk(reg_rdata, e);
  endtask
  task automatic t_reset();
    rd(8'h9A, 8'h00);
    rd(8'h9C, 8'h00);
    core.put(8'h9C, 8'hF0, 1'b1);
    rd(8'h9C, 8'h00);
    rd(8'h9D, 8'h00);
  endtask
  task automatic t_refuse();
    core.put(8'h9C, 8'h04, 1'b1);
    core.put(8'h9D, 8'hAA, 1'b1);
    core.put(8'h9D, 8'h55, 1'b1);
    core.put(8'h9C, 8'h06, 1'b1);
    rd(8'h9C, 8'h04);
    core.put(8'h9C, 8'h00, 1'b1);
    core.unlock_go(8'h02);
    chk({7'h00, write_busy}, 8'h00);
  endtask
  task automatic t_write(input logic [7:0] v);
    int n;
    n = 0;
    core.put(8'h9A, v, 1'b1);
    core.put(8'h9B, 8'h85, 1'b1);
    rd(8'h9B, 8'h05);
    core.put(8'h9C, 8'h04, 1'b1);
    core.unlock_go(8'h06);
    chk({7'h00, write_busy}, 8'h01);
    core.put(8'h9C, 8'h00, 1'b1);
    chk({7'h00, write_busy}, 8'h01);
    while (program_done_flag !== 1'b1 && n < 20) begin
      core.put(8'h9C, 8'h00, 1'b0);
      n++;
    end
    chk(8'(n), 8'(WC - 2));
    chk({7'h00, write_busy}, 8'h00);
    core.clear_done();
    chk({7'h00, program_done_flag}, 8'h00);
    core.put(8'h9A, 8'h00, 1'b1);
    core.put(8'h9C, 8'h01, 1'b1);
    rd(8'h9A, v);
    rd(8'h9C, 8'h00);
  endtask
  task automatic t_prog();
    prog_index = 7'h05;
    prog_rd = 1'b1;
    @(posedge clk);
    #1;
    chk(prog_rdata, 8'h00);
    fuse = 1'b1;
    @(posedge clk);
    #1;
    chk(prog_rdata, 8'h0F);
    prog_rd = 1'b0;
  endtask
  task automatic t_abort();
    core.put(8'h9A, 8'h33, 1'b1);
    core.put(8'h9B, 8'h07, 1'b1);
    core.put(8'h9C, 8'h04, 1'b1);
    core.unlock_go(8'h06);
    rstn = 1'b0;
    @(posedge clk);
    #1;
    rstn = 1'b1;
    rd(8'h9C, 8'h08);
    rd(8'h9A, 8'h00);
    rd(8'h9B, 8'h00);
  endtask
  initial begin
    {rstn, fuse, prog_rd, prog_index, err_count, samples_checked} = '0;
    por_event = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    por_event = 1'b0;
    t_reset();
    t_refuse();
    t_write(8'hF0);
    t_write(8'h0F);
    t_prog();
    t_abort();
    stop_test();
  end
  initial begin
    #(400 * 40);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
